// file: rtl/sel_map.svh
`ifndef SEL_MAP_SVH
`define SEL_MAP_SVH

// ==========================================================
// register word indices on the avalon slave
`define SEL_CMD_OFS      2'h0
`define SEL_DATA_OFS     2'h1
`define SEL_CTRL_OFS     2'h2

// ==========================================================
// field positions
`define SEL_CMD_BUSY     31
`define SEL_CMD_OP_MSB   30
`define SEL_CMD_OP_LSB   28
`define SEL_CMD_TO       10
`define SEL_CMD_LOADED   9
`define SEL_CMD_LOC_MSB  8
`define SEL_CTRL_SOFT_RST 0
`define SEL_CTRL_DONE    1
`define SEL_CTRL_VALID   2

// ==========================================================
// reset values and content constants
`define SEL_RST_LOC      9'h000
`define SEL_RST_DATA     8'h00
`define SEL_RST_MAC      48'h0000_0000_0000
`define SEL_MARKER       8'hA5
`define SEL_MAC_LAST     9'h006
`define SEL_RAM_LAST     9'h1FF

// ==========================================================
// serial frame shape and timing
`define SEL_PRE_BITS     5'h03
`define SEL_SHORT_CLKS   5'h0A
`define SEL_LONG_CLKS    5'h12
`define SEL_CLK_NS       4
`define SEL_SK_HALF_NS   64
`define SEL_TIMEOUT_MS   30

`endif

// file: rtl/sel_pkg.sv
package sel_pkg;

    typedef enum logic [2:0] {
        OP_READ   = 3'b000,
        OP_WR_DIS = 3'b001,
        OP_WR_EN  = 3'b010,
        OP_WRITE  = 3'b011,
        OP_WR_ALL = 3'b100,
        OP_ERASE  = 3'b101,
        OP_ER_ALL = 3'b110,
        OP_RELOAD = 3'b111
    } sel_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP   = 2'b10,
        ST_POLL  = 2'b11
    } sel_state_e;

    typedef struct packed {
        logic cs;
        logic sk;
        logic di;
    } sel_rom_pins_s;

endpackage : sel_pkg

// file: rtl/sel_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sel_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : sel_sync2

`default_nettype wire

// file: rtl/sel_loader.sv
// Contract
// - usb reset, power-on, chip reset pin or soft reset start an auto-load
// - auto-load reads byte zero first; content valid only when it is A5h
// - a load started by usb reset refreshes only the mac address bytes
// - valid content is copied into the 512-byte descriptor ram for ep0
// - a wrong marker ends the load; defaults or otp values then apply unless usb reset started it
// - usb phy stays disconnected until the post-reset load has finished
// - host commands are accepted only after the post-reset load ends
// - host setting busy starts a command; hardware clears busy when done
// - read fetches the addressed byte into the data register in the same cycle busy clears
// - no ready answer within 30 ms abandons the command and sets timeout
// - erase clears the addressed location when the rom is write-enabled
// - erase-all starts a bulk erase of the whole array
// - write stores the data register at the addressed location
// - write-all stores the data register in every location
// - serial clock runs 3 preamble cycles plus 10 for short commands, 18 for data commands
// - reload repeats the auto-load; loaded bit set only on a valid marker
// - nine address bits go to the rom, 256 or 512 byte parts
// - rom content beats otp configuration, which beats register defaults
`timescale 1ns/1ps
`default_nettype none
`include "sel_map.svh"

module sel_loader import sel_pkg::*; #(
    parameter int TIMEOUT_CYC = `SEL_TIMEOUT_MS * 1000000 / `SEL_CLK_NS
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [1:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    output sel_rom_pins_s      rom_pins,
    input  wire logic          rom_do,
    input  wire logic          chip_reset_pin_n,
    input  wire logic          usb_reset,
    input  wire logic          otp_configured,
    input  wire logic [8:0]    desc_addr,
    output logic      [7:0]    desc_rdata,
    output logic      [47:0]   mac_addr,
    output logic               usb_phy_disconnect,
    output logic      [1:0]    cfg_src
);

    localparam int         HALF   = `SEL_SK_HALF_NS / `SEL_CLK_NS;
    localparam logic [7:0] PH_MID = 8'(HALF - 1);
    localparam logic [7:0] PH_END = 8'(2 * HALF - 1);
    localparam logic [22:0] TO_END = 23'(TIMEOUT_CYC - 1);

    // ==========================================================
    // frame building
    function automatic logic [20:0] frame_of(sel_op_e op, logic [8:0] a, logic [7:0] d);
        logic [20:0] f;
        f = 21'h000000;
        unique case (op)
            OP_READ,
            OP_RELOAD: f = {1'b1, 2'b10, a, 1'b0, d};
            OP_WRITE:  f = {1'b1, 2'b01, a, 1'b0, d};
            OP_ERASE:  f = {1'b1, 2'b11, a, 1'b0, d};
            OP_WR_EN:  f = {1'b1, 2'b00, 2'b11, a[6:0], 1'b0, d};
            OP_WR_DIS: f = {1'b1, 2'b00, 2'b00, a[6:0], 1'b0, d};
            OP_ER_ALL: f = {1'b1, 2'b00, 2'b10, a[6:0], 1'b0, d};
            OP_WR_ALL: f = {1'b1, 2'b00, 2'b01, a[6:0], 1'b0, d};
        endcase
        return f;
    endfunction : frame_of

    // ==========================================================
    // state
    sel_state_e    state_q;
    sel_op_e       eng_op_q;
    sel_op_e       op_q;
    sel_rom_pins_s rom_q;
    logic [8:0]    loc_q;
    logic [7:0]    data_q;
    logic          busy_q;
    logic          to_q;
    logic          loaded_q;
    logic          loading_q;
    logic          mac_only_q;
    logic          host_reload_q;
    logic          load_done_q;
    logic          cfg_valid_q;
    logic          por_pend_q;
    logic          pin_prev_q;
    logic [8:0]    ld_addr_q;
    logic [20:0]   sh_q;
    logic [7:0]    rx_q;
    logic [7:0]    ph_q;
    logic [4:0]    bit_q;
    logic [4:0]    nbits_q;
    logic [22:0]   to_cnt_q;
    logic          wait_q;
    logic [31:0]   rdata_q;
    logic [7:0]    desc_q;
    logic [47:0]   mac_q;
    logic          disc_q;
    logic [1:0]    src_q;
    logic [7:0]    ram_q [0:`SEL_RAM_LAST];
    logic [1:0]    sync_q;
    logic          go_q;
    sel_op_e       go_op_q;
    logic [20:0]   go_frame_q;
    logic [4:0]    go_nbits_q;

    sel_sync2 #(.W(2)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({rom_do, ~chip_reset_pin_n}),
        .q     (sync_q)
    );

    // ==========================================================
    // decode
    wire        do_s      = sync_q[1];
    // pin synced inverted so the cleared stage reads as idle high: no false rise after reset
    wire        pin_s     = ~sync_q[0];
    wire        pin_rise  = pin_s & ~pin_prev_q;
    wire        wr_go     = avs_write & ~wait_q;
    wire        wr_cmd    = wr_go & (avs_address == `SEL_CMD_OFS);
    wire        wr_data   = wr_go & (avs_address == `SEL_DATA_OFS) & avs_byteenable[0];
    wire        wr_ctrl   = wr_go & (avs_address == `SEL_CTRL_OFS) & avs_byteenable[0];
    wire        host_ok   = load_done_q & ~loading_q & ~busy_q;
    wire        cmd_go    = wr_cmd & host_ok & avs_byteenable[3]
                            & avs_writedata[`SEL_CMD_BUSY];
    wire        cmd_upd   = wr_cmd & host_ok;
    wire sel_op_e new_op  = sel_op_e'(avs_writedata[`SEL_CMD_OP_MSB:`SEL_CMD_OP_LSB]);
    wire [8:0]  new_loc   = avs_byteenable[1:0] == 2'b11 ? avs_writedata[8:0] : loc_q;
    wire        soft_go   = wr_ctrl & avs_writedata[`SEL_CTRL_SOFT_RST];
    wire        host_rld  = cmd_go & (new_op == OP_RELOAD);
    wire        start_full = por_pend_q | pin_rise | soft_go | host_rld;
    wire        start_mac = usb_reset & ~start_full;
    wire        start_host = cmd_go & ~host_rld;

    wire        wr_type   = (eng_op_q == OP_WRITE) | (eng_op_q == OP_WR_ALL)
                            | (eng_op_q == OP_ERASE) | (eng_op_q == OP_ER_ALL);
    wire        tick_end  = (state_q == ST_SHIFT) & (ph_q == PH_END);
    wire        last_tick = tick_end & (bit_q == nbits_q - 5'h01);
    wire        to_hit    = (state_q == ST_POLL) & ~do_s & (to_cnt_q == TO_END);
    // the first two poll samples still carry the released line through the synchroniser
    wire        poll_ok   = (state_q == ST_POLL) & do_s & (to_cnt_q > 23'h000001);
    wire        fin       = (last_tick & ~wr_type) | poll_ok | to_hit;
    wire [7:0]  rx_next   = {rx_q[6:0], do_s};

    // load sequencing
    wire        bad_mark  = (ld_addr_q == 9'h000) & (rx_next != `SEL_MARKER);
    wire [8:0]  ld_last   = mac_only_q ? `SEL_MAC_LAST : `SEL_RAM_LAST;
    wire        ld_fin    = fin & loading_q;
    wire        ld_end    = ld_fin & (bad_mark | (ld_addr_q == ld_last));
    wire        ld_more   = ld_fin & ~ld_end;
    wire [8:0]  ld_next   = ld_addr_q + 9'h001;
    wire        ram_we    = ld_fin & ~bad_mark & ~mac_only_q;
    wire        mac_we    = ld_fin & ~bad_mark & (ld_addr_q != 9'h000)
                            & (ld_addr_q <= `SEL_MAC_LAST);
    wire [2:0]  mac_idx   = ld_addr_q[2:0] - 3'h1;

    // frame launch selection
    wire        ld_start  = start_full | start_mac;
    wire        launch    = ld_start | start_host | ld_more;
    wire sel_op_e l_op    = ld_start | ld_more ? OP_READ : new_op;
    wire [8:0]  l_addr    = ld_start ? 9'h000 : (ld_more ? ld_next : new_loc);
    wire [20:0] l_frame   = frame_of(l_op, l_addr, data_q);
    wire        l_long    = (l_op == OP_READ) | (l_op == OP_WRITE) | (l_op == OP_WR_ALL);
    wire [4:0]  l_nbits   = `SEL_PRE_BITS + (l_long ? `SEL_LONG_CLKS : `SEL_SHORT_CLKS);

    wire [31:0] cmd_word  = {busy_q, op_q, 17'h00000, to_q, loaded_q, loc_q};
    wire [31:0] rd_mux    = avs_address == `SEL_CMD_OFS  ? cmd_word :
                            avs_address == `SEL_DATA_OFS ? {24'h000000, data_q} :
                            avs_address == `SEL_CTRL_OFS ?
                            {29'h00000000, cfg_valid_q, load_done_q, 1'b0} : 32'h00000000;

    // ==========================================================
    // avalon slave: one wait cycle per access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q  <= ~((avs_read | avs_write) & wait_q);
            if (avs_read & wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ==========================================================
    // host registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_q   <= OP_READ;
            loc_q  <= `SEL_RST_LOC;
            data_q <= `SEL_RST_DATA;
            busy_q <= 1'b0;
            to_q   <= 1'b0;
        end else begin
            if (cmd_upd & avs_byteenable[3]) begin
                op_q <= new_op;
            end
            if (cmd_upd) begin
                loc_q <= new_loc;
            end
            // data register is frozen while a command runs
            if (wr_data & ~busy_q) begin
                data_q <= avs_writedata[7:0];
            end else if (fin & ~loading_q & (eng_op_q == OP_READ)) begin
                data_q <= rx_next;
            end
            if (cmd_go) begin
                busy_q <= 1'b1;
            end else if ((fin & ~loading_q) | (ld_end & host_reload_q)) begin
                busy_q <= 1'b0;
            end else if (ld_start & ~host_rld) begin
                busy_q <= 1'b0;
            end
            // timeout sets win over a software clear
            if (to_hit) begin
                to_q <= 1'b1;
            end else if (wr_cmd & avs_byteenable[1] & avs_writedata[`SEL_CMD_TO]) begin
                to_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // load control
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            por_pend_q    <= 1'b1;
            pin_prev_q    <= 1'b1;
            loading_q     <= 1'b0;
            mac_only_q    <= 1'b0;
            host_reload_q <= 1'b0;
            load_done_q   <= 1'b0;
            loaded_q      <= 1'b0;
            cfg_valid_q   <= 1'b0;
            ld_addr_q     <= 9'h000;
        end else begin
            por_pend_q <= 1'b0;
            pin_prev_q <= pin_s;
            if (ld_start) begin
                loading_q     <= 1'b1;
                mac_only_q    <= start_mac;
                host_reload_q <= host_rld;
                ld_addr_q     <= 9'h000;
                if (start_full) begin
                    load_done_q <= 1'b0;
                    loaded_q    <= 1'b0;
                end
            end else if (ld_end) begin
                loading_q   <= 1'b0;
                load_done_q <= 1'b1;
                loaded_q    <= ~bad_mark;
                if (!mac_only_q) begin
                    cfg_valid_q <= ~bad_mark;
                end
            end else if (ld_more) begin
                ld_addr_q <= ld_next;
            end
        end
    end

    // ==========================================================
    // serial engine; every frame starts two cycles after launch, chip select low between
    always_ff @(posedge clk) begin
        go_q       <= rst_n & launch;
        go_op_q    <= l_op;
        go_frame_q <= l_frame;
        go_nbits_q <= l_nbits;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            eng_op_q <= OP_READ;
            rom_q    <= '0;
            sh_q     <= 21'h000000;
            rx_q     <= 8'h00;
            ph_q     <= 8'h00;
            bit_q    <= 5'h00;
            nbits_q  <= 5'h00;
            to_cnt_q <= 23'h000000;
        end else if (go_q) begin
            state_q  <= ST_SHIFT;
            eng_op_q <= go_op_q;
            sh_q     <= go_frame_q;
            nbits_q  <= go_nbits_q;
            bit_q    <= 5'h00;
            ph_q     <= 8'h00;
            rom_q    <= '{cs: 1'b1, sk: 1'b0, di: go_frame_q[20]};
        end else if (launch) begin
            // a new load preempts whatever frame was running
            state_q  <= ST_IDLE;
            rom_q    <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    rom_q <= '0;
                end
                ST_SHIFT: begin
                    ph_q <= tick_end ? 8'h00 : ph_q + 8'h01;
                    if (ph_q == PH_MID) begin
                        rom_q.sk <= 1'b1;
                    end
                    if (tick_end) begin
                        rom_q.sk <= 1'b0;
                        rx_q     <= rx_next;
                        sh_q     <= {sh_q[19:0], 1'b0};
                        rom_q.di <= sh_q[19];
                        bit_q    <= bit_q + 5'h01;
                    end
                    if (last_tick) begin
                        rom_q.cs <= 1'b0;
                        rom_q.di <= 1'b0;
                        state_q  <= wr_type ? ST_GAP : ST_IDLE;
                    end
                end
                ST_GAP: begin
                    // chip select low for one serial clock period (32 clk) before status polling
                    ph_q <= ph_q + 8'h01;
                    if (ph_q == PH_END) begin
                        rom_q.cs <= 1'b1;
                        to_cnt_q <= 23'h000000;
                        state_q  <= ST_POLL;
                    end
                end
                ST_POLL: begin
                    to_cnt_q <= to_cnt_q + 23'h000001;
                    if (poll_ok | to_hit) begin
                        rom_q.cs <= 1'b0;
                        state_q  <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // descriptor ram, mac and status outputs
    always_ff @(posedge clk) begin
        if (ram_we) begin
            ram_q[ld_addr_q] <= rx_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            desc_q <= 8'h00;
            mac_q  <= `SEL_RST_MAC;
            disc_q <= 1'b1;
            src_q  <= 2'b00;
        end else begin
            desc_q <= ram_q[desc_addr];
            if (mac_we) begin
                mac_q[{mac_idx, 3'b000} +: 8] <= rx_next;
            end
            // a mac-only load disconnects the phy for one clock at its start, then keeps it attached
            disc_q <= ~load_done_q | (loading_q & ~mac_only_q) | ld_start;
            src_q  <= cfg_valid_q ? 2'b10 : (otp_configured ? 2'b01 : 2'b00);
        end
    end

    assign avs_readdata       = rdata_q;
    assign avs_waitrequest    = wait_q;
    assign rom_pins           = rom_q;
    assign desc_rdata         = desc_q;
    assign mac_addr           = mac_q;
    assign usb_phy_disconnect = disc_q;
    assign cfg_src            = src_q;

    // ==========================================================
    // checks
    logic [4:0] sk_cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n || launch) begin
            sk_cnt_q <= 5'h00;
        end else if ((state_q == ST_SHIFT) && (ph_q == PH_MID)) begin
            sk_cnt_q <= sk_cnt_q + 5'h01;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CMD_REFUSED: assert property (wr_cmd & ~load_done_q |=> ~busy_q)
        else $error("command taken before load finished");
    AST_PHY_HOLD: assert property (~load_done_q |=> usb_phy_disconnect)
        else $error("phy attached before load done");
    AST_MARKER_BAD: assert property (ld_end & bad_mark |=> ~loading_q & ~loaded_q)
        else $error("bad marker did not end the load");
    AST_NO_DEFAULT_RAM: assert property (ld_end & bad_mark & ~mac_only_q
                                         |=> ~cfg_valid_q ##2 cfg_src != 2'b10)
        else $error("bad marker still reports rom content");
    AST_TIMEOUT: assert property (to_hit & ~loading_q |=> to_q & ~busy_q & ~rom_pins.cs)
        else $error("timeout not flagged");
    AST_CLK_COUNT: assert property (last_tick |-> sk_cnt_q - `SEL_PRE_BITS ==
                                    (nbits_q == 5'h15 ? `SEL_LONG_CLKS : `SEL_SHORT_CLKS))
        else $error("wrong serial clock count");
    AST_READ_DATA: assert property (fin & ~loading_q & (eng_op_q == OP_READ) & ~launch
                                    |=> ~busy_q & (data_q == $past(rx_next)))
        else $error("read byte not in data register");
    AST_MAC_ONLY: assert property (loading_q & mac_only_q |-> ~ram_we)
        else $error("usb reset load touched descriptor ram");
    AST_CS_FRAME: assert property (state_q == ST_SHIFT & ~launch |-> rom_pins.cs)
        else $error("chip select dropped inside frame");
    AST_START: assert property (start_full |=> loading_q & ~load_done_q ##1 usb_phy_disconnect)
        else $error("reset did not start a load");
    AST_BUSY_START: assert property (cmd_go & ~host_rld |=> busy_q ##1 state_q == ST_SHIFT)
        else $error("busy write did not start a frame");

    COV_FULL_LOAD: cover property (ld_end & ~bad_mark & ~mac_only_q);
    COV_BAD_MARK: cover property (ld_end & bad_mark);
    COV_WRITE_POLL: cover property (poll_ok & ~loading_q);
    COV_TIMEOUT: cover property (to_hit);

endmodule : sel_loader

`default_nettype wire

// file: verification/sel_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// serial rom model; write-type frames sent while write-enabled end busy for 300 clk
module sel_rom_model import sel_pkg::*; (
    input  wire sel_rom_pins_s pins,
    input  wire logic          clk,
    output logic               rom_do
);
    logic [7:0]  mem [0:511];
    logic        ew_q  = 1'b0;
    logic        stuck = 1'b0;
    logic        sk_q  = 1'b0;
    logic        cs_q  = 1'b0;
    logic        tog   = 1'b0;
    logic [20:0] sr    = '0;
    logic [8:0]  a     = '0;
    logic [1:0]  o     = '0;
    int          n     = 0;
    int          bsy   = 0;
    // released line toggles so no stale level is seen
    assign rom_do = !pins.cs ? tog : (n > 13 && o == 2'b10) ? mem[a][21-n] :
                    (n == 0) ? (bsy == 0 && !stuck) : tog;
    always @(posedge clk) begin
        sk_q <= pins.sk;
        cs_q <= pins.cs;
        tog <= ~tog;
        if (bsy > 0) bsy <= bsy - 1;
        if (!pins.cs) n <= 0;
        else if (pins.sk && !sk_q) begin
            n <= n + 1;
            sr <= {sr[19:0], pins.di};
            if (n == 12) a <= sr[8:0];
            if (n == 12) o <= sr[10:9];
        end
        if (cs_q && !pins.cs && n > 12 && o == 2'b00) begin
            if (a[8:7] == 2'b11) ew_q <= 1'b1;
            if (a[8:7] == 2'b00) ew_q <= 1'b0;
        end
        if (cs_q && !pins.cs && n > 12 && ew_q && o != 2'b10) begin
            bsy <= 300;
            for (int i = 0; i < 512; i++) begin
                if (o == 2'b01 && i == a) mem[i] = sr[7:0];
                if (o == 2'b11 && i == a) mem[i] = 8'hFF;
                if (o == 2'b00 && a[8:7] == 2'b10) mem[i] = 8'hFF;
                if (o == 2'b00 && a[8:7] == 2'b01) mem[i] = sr[7:0];
            end
        end
    end
endmodule : sel_rom_model
`default_nettype wire

// file: verification/serial_eeprom_loader_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_loader_ctrl_tb import sel_pkg::*;;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic [1:0]    adr = 2'h0;
    logic          rd = 1'b0;
    logic          wr = 1'b0;
    logic [31:0]   wd = 32'h0;
    logic [31:0]   rdat;
    logic          wq;
    sel_rom_pins_s pins;
    logic          rdo;
    logic          crst_n = 1'b1;
    logic          usb = 1'b0;
    logic          otp = 1'b1;
    logic [7:0]    drd;
    logic [47:0]   mac;
    logic          disc;
    logic [1:0]    src;
    logic          skq = 1'b0;
    logic          csq = 1'b0;
    int            skc = 0;
    int            fcnt = 0;
    int            failures = 0;
    int            cmp_count = 0;
    sel_loader #(.TIMEOUT_CYC(2000)) uut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(wq), .rom_pins(pins), .rom_do(rdo),
        .chip_reset_pin_n(crst_n), .usb_reset(usb), .otp_configured(otp),
        .desc_addr(9'h007), .desc_rdata(drd), .mac_addr(mac),
        .usb_phy_disconnect(disc), .cfg_src(src));
    sel_rom_model rom (.pins(pins), .clk(clk), .rom_do(rdo));
    // ==========================================================
    // clock, edge counters, watchdog
    always #2 clk = ~clk;
    always @(posedge clk) begin
        skq <= pins.sk;
        csq <= pins.cs;
        if (pins.sk && !skq) skc++;
        if (csq && !pins.cs) fcnt++;
    end
    initial begin
        #(50000 * 4);
        failures++;
        print_verdict();
    end
    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    // ==========================================================
    // avalon master: hold until waitrequest sampled low
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 50);
        if (wq !== 1'b0) failures++;
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic wait_bit(input logic [1:0] a, input int b, input logic v);
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0, q);
            n++;
        end while (q[b] !== v && n < 20000);
        if (q[b] !== v) failures++;
    endtask : wait_bit
    task automatic wait_fr(input int k);
        int n;
        n = 0;
        while (fcnt < k && n < 60000) begin
            @(posedge clk);
            n++;
        end
        if (fcnt < k) failures++;
    endtask : wait_fr
    task automatic cmd(input logic [2:0] op, input logic [8:0] loc, input int p);
        logic [31:0] q;
        skc = 0;
        bus(1'b1, 2'h0, {1'b1, op, 19'h0, loc}, q);
        wait_bit(2'h0, 31, 1'b0);
        chk(p, skc);
    endtask : cmd
    // ==========================================================
    // scenarios
    task automatic t_boot;
        logic [31:0] q;
        @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b1, 2'h0, 32'hC000_0000, q);
        chk(1'b1, disc);
        wait_bit(2'h2, 1, 1'b1);
        bus(1'b0, 2'h0, 32'h0, q);
        chk(4'h0, q[31:28]);
        bus(1'b0, 2'h2, 32'h0, q);
        chk(3'b010, q[2:0]);
        chk(2'b01, src);
        chk(1'b0, disc);
        otp <= 1'b0;
        repeat (2) @(posedge clk);
        chk(2'b00, src);
        otp <= 1'b1;
    endtask : t_boot
    task automatic t_usb;
        logic [31:0] q;
        rom.mem[0] = 8'hA5;
        fcnt = 0;
        @(posedge clk);
        usb <= 1'b1;
        @(posedge clk);
        usb <= 1'b0;
        wait_fr(7);
        repeat (1000) @(posedge clk);
        chk(7, fcnt);
        chk(48'h6655_4433_2211, mac);
        bus(1'b0, 2'h0, 32'h0, q);
        chk(1'b1, q[9]);
    endtask : t_usb
    task automatic t_ops;
        logic [31:0] q;
        cmd(OP_WR_EN, 9'h000, 13);
        bus(1'b1, 2'h1, 32'h5A, q);
        cmd(OP_WRITE, 9'h1A5, 21);
        chk(8'h5A, rom.mem[9'h1A5]);
        bus(1'b1, 2'h1, 32'h0, q);
        cmd(OP_READ, 9'h1A5, 21);
        bus(1'b0, 2'h1, 32'h0, q);
        chk(8'h5A, q[7:0]);
        cmd(OP_ERASE, 9'h1A5, 13);
        chk(8'hFF, rom.mem[9'h1A5]);
        bus(1'b1, 2'h1, 32'h33, q);
        cmd(OP_WR_ALL, 9'h000, 21);
        chk(16'h3333, {rom.mem[0], rom.mem[511]});
        cmd(OP_ER_ALL, 9'h000, 13);
        chk(16'hFFFF, {rom.mem[0], rom.mem[300]});
        rom.stuck = 1'b1;
        cmd(OP_ERASE, 9'h010, 13);
        rom.stuck = 1'b0;
        bus(1'b0, 2'h0, 32'h0, q);
        chk(1'b1, q[10]);
        bus(1'b1, 2'h0, 32'h0000_0400, q);
        bus(1'b0, 2'h0, 32'h0, q);
        chk(1'b0, q[10]);
        cmd(OP_WR_DIS, 9'h000, 13);
        cmd(OP_RELOAD, 9'h000, 21);
        bus(1'b0, 2'h0, 32'h0, q);
        chk(1'b0, q[9]);
    endtask : t_ops
    task automatic t_rst;
        logic [31:0] q;
        fcnt = 0;
        rom.mem[0] = 8'hA5;
        rom.mem[7] = 8'h77;
        bus(1'b1, 2'h2, 32'h1, q);
        wait_fr(8);
        repeat (2) @(posedge clk);
        chk(8, fcnt);
        chk(8'h77, drd);
        rom.mem[0] = 8'hFF;
        crst_n <= 1'b0;
        repeat (4) @(posedge clk);
        crst_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk(1'b1, disc);
        wait_fr(10);
        chk(10, fcnt);
        wait_bit(2'h2, 1, 1'b1);
        chk(1'b0, disc);
    endtask : t_rst
    initial begin
        for (int i = 0; i < 512; i++) rom.mem[i] = (i < 8) ? 8'(i * 17) : 8'h00;
        rom.mem[0] = 8'h3C;
        repeat (6) @(posedge clk);
        t_boot();
        t_usb();
        t_ops();
        t_rst();
        print_verdict();
    end
endmodule : serial_eeprom_loader_ctrl_tb
`default_nettype wire
